// *** core/svr_top.sv ***
/*
  Supply supervisor pin logic: system reset with stretch, rail fail
  flags, early low supply flag, manual reset debounce and a watchdog
  restarted by two-wire bus start/clock/stop activity.
  Assumes comparator results and all pins arrive asynchronously; the
  period selects and the bus engine hooks are on the mclk_i domain.
*/
`timescale 1ns/1ps

// Functional notes
// R01 - Second rail fail low while rail below threshold
// R02 - Third rail fail low while rail below threshold
// R03 - Early low supply follows main comparator, push-pull
// R04 - Manual reset low starts system reset
// R05 - Reset held while button low, plus stretch
// R06 - Active-low variant pulls open-drain reset low
// R07 - Active-high variant drives push-pull reset high
// R08 - Reset held one stretch period at power-up
// R09 - Start, clock fall, stop restarts watchdog
// R10 - No restart within period asserts expiry
// R11 - Expiry output is active-low open-drain
// R12 - Write protect high blocks every write
// R13 - Data line open-drain, never driven high
// R14 - Data input sampled always, never gated
// R15 - Any complete bus transfer restarts watchdog
// R16 - Two stored bits select watchdog period
// R17 - Manual reset synchronised and debounced
// R18 - Comparator inputs synchronised before use
module svr_top #(
  parameter bit ACTIVE_HIGH_RESET = 1'b0,
  parameter int STRETCH_CYC0 = svr_pkg::STRETCH0_CYC,
  parameter int STRETCH_CYC1 = svr_pkg::STRETCH1_CYC,
  parameter int STRETCH_CYC2 = svr_pkg::STRETCH2_CYC,
  parameter int STRETCH_CYC3 = svr_pkg::STRETCH3_CYC,
  parameter int WD_CYC0 = svr_pkg::WD0_CYC,
  parameter int WD_CYC1 = svr_pkg::WD1_CYC,
  parameter int WD_CYC2 = svr_pkg::WD2_CYC,
  parameter int WD_CYC3 = svr_pkg::WD3_CYC
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic main_supply_ok_i,
  input wire logic second_rail_ok_i,
  input wire logic third_rail_ok_i,
  input wire logic manual_reset_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic write_protect_i,
  input wire logic [1:0] stretch_sel_i,
  input wire logic [1:0] wd_sel_data_i,
  input wire logic wd_sel_wr_i,
  input wire logic sda_drive_low_i,
  output logic sys_reset_o,
  output logic sys_reset_oe_o,
  output logic second_rail_fail_n_o,
  output logic second_rail_fail_n_oe_o,
  output logic third_rail_fail_n_o,
  output logic third_rail_fail_n_oe_o,
  output logic early_low_supply_n_o,
  output logic watchdog_expired_n_o,
  output logic watchdog_expired_n_oe_o,
  output logic sda_o,
  output logic sda_oe_o,
  output logic [1:0] wd_sel_o
);

  function automatic logic [31:0] pick4(input logic [1:0] sel, input logic [31:0] a,
                                        input logic [31:0] b, input logic [31:0] c,
                                        input logic [31:0] d);
    case (sel)
      2'h0: pick4 = a;
      2'h1: pick4 = b;
      2'h2: pick4 = c;
      default: pick4 = d;
    endcase
  endfunction

  logic [svr_pkg::SYN_N-1:0] raw;
  logic [svr_pkg::SYN_N-1:0] sync1_ff;
  logic [svr_pkg::SYN_N-1:0] sync2_ff;
  assign raw = {write_protect_i, sda_i, scl_i, manual_reset_n_i,
                third_rail_ok_i, second_rail_ok_i, main_supply_ok_i};

  // Every pin passes two flops; the data lane is never gated [R14] [R18]
  genvar gi;
  generate
    for (gi = 0; gi < svr_pkg::SYN_N; gi++) begin : g_sync
      always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          sync1_ff[gi] <= 1'h0;
          sync2_ff[gi] <= 1'h0;
        end else begin
          sync1_ff[gi] <= raw[gi];
          sync2_ff[gi] <= sync1_ff[gi];
        end
      end
    end
  endgenerate

  logic main_s;
  logic rail2_s;
  logic rail3_s;
  logic mr_s;
  logic scl_s;
  logic sda_s;
  logic wp_s;
  assign main_s = sync2_ff[svr_pkg::SYN_MAIN];
  assign rail2_s = sync2_ff[svr_pkg::SYN_RAIL2];
  assign rail3_s = sync2_ff[svr_pkg::SYN_RAIL3];
  assign mr_s = sync2_ff[svr_pkg::SYN_MR];
  assign scl_s = sync2_ff[svr_pkg::SYN_SCL];
  assign sda_s = sync2_ff[svr_pkg::SYN_SDA];
  assign wp_s = sync2_ff[svr_pkg::SYN_WP];

  // Manual reset debounce: a level must hold a full window to be taken
  logic mr_db_ff;
  logic nxt_mr_db;
  logic [svr_pkg::DB_W-1:0] db_cnt_ff;
  logic [svr_pkg::DB_W-1:0] nxt_db_cnt;
  always_comb begin
    nxt_mr_db = mr_db_ff;
    nxt_db_cnt = '0;
    if (mr_s != mr_db_ff) begin
      if (db_cnt_ff == svr_pkg::DB_W'(svr_pkg::DEBOUNCE_CYC - 1)) begin
        nxt_mr_db = mr_s; // [R17]
      end else begin
        nxt_db_cnt = db_cnt_ff + svr_pkg::DB_W'(1);
      end
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mr_db_ff <= 1'h1;
      db_cnt_ff <= '0;
    end else begin
      mr_db_ff <= nxt_mr_db;
      db_cnt_ff <= nxt_db_cnt;
    end
  end

  // System reset with stretch; reset release also starts a stretch
  logic [31:0] stretch_lim;
  logic rst_cause;
  logic rst_act_ff;
  logic nxt_rst_act;
  logic [31:0] rst_cnt_ff;
  logic [31:0] nxt_rst_cnt;
  logic sys_reset_ff;
  logic nxt_sys_reset;
  logic sys_reset_oe_ff;
  logic nxt_sys_reset_oe;
  assign stretch_lim = pick4(stretch_sel_i, 32'(STRETCH_CYC0), 32'(STRETCH_CYC1),
                             32'(STRETCH_CYC2), 32'(STRETCH_CYC3));
  assign rst_cause = !main_s || !mr_db_ff; // [R04] [R06] [R07]
  always_comb begin
    nxt_rst_cnt = rst_cnt_ff;
    if (rst_cause) begin
      nxt_rst_cnt = 32'h0000_0000; // [R05]
    end else if (rst_cnt_ff < stretch_lim) begin
      nxt_rst_cnt = rst_cnt_ff + 32'h0000_0001; // [R08]
    end
    nxt_rst_act = rst_cause || (nxt_rst_cnt < stretch_lim);
    // Open-drain variant only pulls low; push-pull variant drives both ways
    nxt_sys_reset = ACTIVE_HIGH_RESET ? nxt_rst_act : 1'h0; // [R06] [R07]
    nxt_sys_reset_oe = ACTIVE_HIGH_RESET ? 1'h1 : nxt_rst_act;
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_act_ff <= 1'h1;
      rst_cnt_ff <= 32'h0000_0000;
      sys_reset_ff <= ACTIVE_HIGH_RESET;
      sys_reset_oe_ff <= 1'h1;
    end else begin
      rst_act_ff <= nxt_rst_act;
      rst_cnt_ff <= nxt_rst_cnt;
      sys_reset_ff <= nxt_sys_reset;
      sys_reset_oe_ff <= nxt_sys_reset_oe;
    end
  end

  // Rail flags carry no stretch, only the synchroniser delay and one output flop
  logic rail2_oe_ff;
  logic rail3_oe_ff;
  logic early_low_ff;
  logic sda_oe_ff;
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rail2_oe_ff <= 1'h1;
      rail3_oe_ff <= 1'h1;
      early_low_ff <= 1'h0;
      sda_oe_ff <= 1'h0;
    end else begin
      rail2_oe_ff <= !rail2_s; // [R01]
      rail3_oe_ff <= !rail3_s; // [R02]
      early_low_ff <= main_s; // [R03]
      sda_oe_ff <= sda_drive_low_i; // [R13]
    end
  end

  // Watchdog restart sequence detector
  logic scl_prev_ff;
  logic sda_prev_ff;
  logic bus_start;
  logic bus_stop;
  logic scl_fall;
  logic kick;
  svr_pkg::svr_wd_state_t wd_st_ff;
  svr_pkg::svr_wd_state_t nxt_wd_st;
  assign bus_start = scl_s && scl_prev_ff && sda_prev_ff && !sda_s;
  assign bus_stop = scl_s && scl_prev_ff && !sda_prev_ff && sda_s;
  assign scl_fall = scl_prev_ff && !scl_s;

  always_comb begin
    nxt_wd_st = wd_st_ff;
    kick = 1'h0;
    case (wd_st_ff)
      svr_pkg::SVR_WD_IDLE: begin
        if (bus_start) begin
          nxt_wd_st = svr_pkg::SVR_WD_START;
        end
      end
      svr_pkg::SVR_WD_START: begin
        if (bus_stop) begin
          nxt_wd_st = svr_pkg::SVR_WD_IDLE;
        end else if (scl_fall) begin
          nxt_wd_st = svr_pkg::SVR_WD_CLKLO;
        end
      end
      svr_pkg::SVR_WD_CLKLO: begin
        // Full transfers pass through here too, so they restart as well
        if (bus_stop) begin
          kick = 1'h1; // [R09] [R15]
          nxt_wd_st = svr_pkg::SVR_WD_IDLE;
        end else if (bus_start) begin
          nxt_wd_st = svr_pkg::SVR_WD_START;
        end
      end
      default: nxt_wd_st = svr_pkg::SVR_WD_IDLE;
    endcase
  end

  // Watchdog period select and timer
  logic [1:0] wd_sel_ff;
  logic [1:0] nxt_wd_sel;
  logic sel_wr_ok;
  logic [31:0] wd_lim;
  logic [31:0] wd_cnt_ff;
  logic [31:0] nxt_wd_cnt;
  logic wd_oe_ff;
  logic nxt_wd_oe;
  assign sel_wr_ok = wd_sel_wr_i && !wp_s; // [R12]
  assign wd_lim = pick4(wd_sel_ff, 32'(WD_CYC0), 32'(WD_CYC1),
                        32'(WD_CYC2), 32'(WD_CYC3)); // [R16]

  always_comb begin
    nxt_wd_sel = sel_wr_ok ? wd_sel_data_i : wd_sel_ff; // [R16]
    nxt_wd_cnt = wd_cnt_ff;
    // A new period restarts the count so the old one cannot trip early
    if (kick || sel_wr_ok) begin
      nxt_wd_cnt = 32'h0000_0000;
    end else if (wd_cnt_ff < wd_lim) begin
      nxt_wd_cnt = wd_cnt_ff + 32'h0000_0001;
    end
    nxt_wd_oe = (nxt_wd_cnt >= wd_lim); // [R10] [R11]
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      scl_prev_ff <= 1'h0;
      sda_prev_ff <= 1'h0;
      wd_st_ff <= svr_pkg::SVR_WD_IDLE;
      wd_sel_ff <= svr_pkg::WD_SEL_RST;
      wd_cnt_ff <= 32'h0000_0000;
      wd_oe_ff <= 1'h0;
    end else begin
      scl_prev_ff <= scl_s;
      sda_prev_ff <= sda_s;
      wd_st_ff <= nxt_wd_st;
      wd_sel_ff <= nxt_wd_sel;
      wd_cnt_ff <= nxt_wd_cnt;
      wd_oe_ff <= nxt_wd_oe;
    end
  end

  // Open-drain lanes only ever drive zero; the pull-up gives the high
  assign sys_reset_o = sys_reset_ff;
  assign sys_reset_oe_o = sys_reset_oe_ff;
  assign second_rail_fail_n_o = 1'h0;
  assign second_rail_fail_n_oe_o = rail2_oe_ff;
  assign third_rail_fail_n_o = 1'h0;
  assign third_rail_fail_n_oe_o = rail3_oe_ff;
  assign early_low_supply_n_o = early_low_ff;
  assign watchdog_expired_n_o = 1'h0;
  assign watchdog_expired_n_oe_o = wd_oe_ff;
  assign sda_o = 1'h0;
  assign sda_oe_o = sda_oe_ff;
  assign wd_sel_o = wd_sel_ff;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!reset_n_i);
  rail2_flag_a: assert property (rail2_s != $past(rail2_s) |=> rail2_oe_ff == !$past(rail2_s)) // [R01]
    else $error("second rail flag does not follow comparator");
  rail3_flag_a: assert property (!rail3_s ##1 !rail3_s |-> third_rail_fail_n_oe_o) // [R02]
    else $error("third rail flag not pulled low");
  early_low_a: assert property (##1 early_low_supply_n_o == $past(main_s)) // [R03]
    else $error("early low flag does not track main supply");
  mr_assert_a: assert property (!mr_db_ff |=> rst_act_ff [*2]) // [R04]
    else $error("manual reset did not assert reset");
  mr_stretch_a: assert property ($rose(mr_db_ff) && main_s |=> rst_act_ff && rst_cnt_ff <= 32'h0000_0001) // [R05]
    else $error("reset released without stretch after button");
  low_variant_a: assert property (!ACTIVE_HIGH_RESET |-> !sys_reset_o && sys_reset_oe_o == rst_act_ff) // [R06]
    else $error("open-drain reset lane wrong");
  high_variant_a: assert property (ACTIVE_HIGH_RESET |-> sys_reset_oe_o && sys_reset_o == rst_act_ff) // [R07]
    else $error("push-pull reset lane wrong");
  por_hold_a: assert property (!rst_cause && rst_cnt_ff + 32'h0000_0001 < stretch_lim |=> rst_act_ff) // [R08]
    else $error("reset released before stretch end");
  wd_kick_a: assert property (kick |=> wd_cnt_ff == 32'h0000_0000 ##1 !wd_oe_ff) // [R09]
    else $error("watchdog not restarted by sequence");
  wd_expire_a: assert property (wd_cnt_ff + 32'h0000_0001 == wd_lim && !kick && !sel_wr_ok |=> watchdog_expired_n_oe_o) // [R10]
    else $error("watchdog expiry missed");
  wd_pin_a: assert property (!watchdog_expired_n_o && (wd_oe_ff == (wd_cnt_ff >= wd_lim))) // [R11]
    else $error("expiry lane inconsistent");
  wp_block_a: assert property (wp_s && wd_sel_wr_i |=> wd_sel_o == $past(wd_sel_o)) // [R12]
    else $error("write accepted under write protect");
  sda_low_a: assert property (!sda_o) // [R13]
    else $error("data line driven high");
  wd_ctrl_a: assert property (bus_stop && wd_st_ff == svr_pkg::SVR_WD_CLKLO |-> kick) // [R15]
    else $error("transfer end did not restart watchdog");
  db_hold_a: assert property ($changed(mr_db_ff) |-> $past(db_cnt_ff) == svr_pkg::DB_W'(svr_pkg::DEBOUNCE_CYC - 1)) // [R17]
    else $error("manual reset level taken before debounce");

  kick_c: cover property (kick);
  expire_c: cover property ($rose(wd_oe_ff));
  mr_release_c: cover property ($rose(mr_db_ff) ##[1:200] !rst_act_ff);
  wp_block_c: cover property (wp_s && wd_sel_wr_i);
endmodule

// *** core/svr_pkg.sv ***
/*
  Shared constants for the supply supervisor: clock rate, stretch and
  watchdog periods, debounce time and the watchdog sequence states.
  Assumes a single 125 MHz clock; the real periods come from the
  top-level parameters, which default to the counts derived here.
*/
package svr_pkg;

  localparam int CLK_PERIOD_NS = 8;
  localparam int NS_PER_MS = 1000000;
  localparam int CYC_PER_MS = NS_PER_MS / CLK_PERIOD_NS;

  // Reset stretch choices (least times, exact in whole cycles here)
  localparam int STRETCH0_MS = 10;
  localparam int STRETCH1_MS = 20;
  localparam int STRETCH2_MS = 40;
  localparam int STRETCH3_MS = 80;
  localparam int STRETCH0_CYC = STRETCH0_MS * CYC_PER_MS;
  localparam int STRETCH1_CYC = STRETCH1_MS * CYC_PER_MS;
  localparam int STRETCH2_CYC = STRETCH2_MS * CYC_PER_MS;
  localparam int STRETCH3_CYC = STRETCH3_MS * CYC_PER_MS;

  // Watchdog timeout choices (longest times)
  localparam int WD0_MS = 16;
  localparam int WD1_MS = 32;
  localparam int WD2_MS = 64;
  localparam int WD3_MS = 128;
  localparam int WD0_CYC = WD0_MS * CYC_PER_MS;
  localparam int WD1_CYC = WD1_MS * CYC_PER_MS;
  localparam int WD2_CYC = WD2_MS * CYC_PER_MS;
  localparam int WD3_CYC = WD3_MS * CYC_PER_MS;

  // Manual reset debounce, least time rounded up
  localparam int DEBOUNCE_NS = 5000;
  localparam int DEBOUNCE_CYC = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int CNT_W = 32;
  localparam int DB_W = 12;
  localparam logic [1:0] WD_SEL_RST = 2'h0;

  // Synchroniser lane positions
  localparam int SYN_MAIN = 0;
  localparam int SYN_RAIL2 = 1;
  localparam int SYN_RAIL3 = 2;
  localparam int SYN_MR = 3;
  localparam int SYN_SCL = 4;
  localparam int SYN_SDA = 5;
  localparam int SYN_WP = 6;
  localparam int SYN_N = 7;

  typedef enum logic [2:0] {
    SVR_WD_IDLE = 3'h1,
    SVR_WD_START = 3'h2,
    SVR_WD_CLKLO = 3'h4
  } svr_wd_state_t;

endpackage

// *** dv/svr_host_model.sv ***
/*
  Host side of the two-wire bus as seen by the supervisor: a behavioural
  master that makes start, clock and stop patterns on demand.
  Assumes the bench resolves the data line with a pull-up.
*/
`timescale 1ns/1ps
module svr_host_model (
  input wire logic mclk_i,
  output logic scl_o,
  output logic sda_low_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // Phases last several cycles so the device synchroniser sees each one
  task automatic step(input logic scl_v, input logic low_v);
    @(negedge mclk_i);
    scl_o <= scl_v;
    sda_low_o <= low_v;
    repeat (8) @(negedge mclk_i);
  endtask
  // Data is only ever pulled low; the pull-up makes the high level
  task automatic kick(input logic with_clock);
    step(1'b1, 1'b1);
    if (with_clock) begin
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
    end
    step(1'b1, 1'b0);
  endtask
endmodule

// *** dv/supervisor_reset_watchdog_pins_test.sv ***
/*
  Self-checking bench for the supervisor pin logic: rail flags, reset
  stretch, manual reset debounce, watchdog restart and write protect.
  Assumes the active-low reset variant and shortened period counts.
*/
`timescale 1ns/1ps
module supervisor_reset_watchdog_pins_test;
  localparam int ST0 = 40;
  localparam int ST1 = 60;
  localparam int ST2 = 80;
  localparam int WD0 = 200;
  localparam int WD1 = 300;
  logic mclk_i, reset_n_i, main_ok, r2_ok, r3_ok, mr_n, wp, wr, drive_low;
  logic [1:0] st_sel, wd_data, wd_sel;
  logic rst, rst_oe, r2_oe, r3_oe, early_n, wdo_oe, sda_o, sda_oe, scl, host_low, seen;
  logic r2_pin, r3_pin, wdo_pin;
  wire logic sda_w = !(host_low | sda_oe);
  int bad_count = 0;
  int checks_done = 0;
  // Columns: main, rail2, rail3 ok | early low, rail2 pull, rail3 pull
  logic [5:0] rows [4] = '{6'h3c, 6'h2e, 6'h35, 6'h03};

  // Last stretch select and upper watchdog selects keep long defaults, unused in this run
  svr_top #(.STRETCH_CYC0(ST0), .STRETCH_CYC1(ST1), .STRETCH_CYC2(ST2), .WD_CYC0(WD0),
    .WD_CYC1(WD1)) uut (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .main_supply_ok_i(main_ok),
    .second_rail_ok_i(r2_ok), .third_rail_ok_i(r3_ok), .manual_reset_n_i(mr_n),
    .scl_i(scl), .sda_i(sda_w), .write_protect_i(wp), .stretch_sel_i(st_sel),
    .wd_sel_data_i(wd_data), .wd_sel_wr_i(wr), .sda_drive_low_i(drive_low),
    .sys_reset_o(rst), .sys_reset_oe_o(rst_oe), .second_rail_fail_n_o(r2_pin),
    .second_rail_fail_n_oe_o(r2_oe), .third_rail_fail_n_o(r3_pin), .third_rail_fail_n_oe_o(r3_oe),
    .early_low_supply_n_o(early_n), .watchdog_expired_n_o(wdo_pin),
    .watchdog_expired_n_oe_o(wdo_oe),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .wd_sel_o(wd_sel));
  svr_host_model host (.mclk_i(mclk_i), .scl_o(scl), .sda_low_o(host_low));

  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    if (bad_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask

  task automatic wait_rst(input logic v, input int n);
    for (int i = 0; i < n && rst_oe !== v; i++) @(negedge mclk_i);
  endtask

  task automatic sel_write(input logic [1:0] v);
    wd_data = v;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
    cyc(3);
  endtask

  initial begin
    {main_ok, r2_ok, r3_ok, mr_n} = 4'hf;
    {reset_n_i, wp, wr, drive_low} = 4'h0;
    st_sel = 2'h0;
    wd_data = 2'h0;
    cyc(20);
    chk({rst, rst_oe, wdo_oe, sda_oe, wd_sel, r2_oe, r3_oe, early_n}, 12'h086);
    reset_n_i = 1'b1;
    cyc(ST0 - 4);
    chk(rst_oe, 1'b1);
    wait_rst(1'b0, 20);
    chk(rst_oe, 1'b0);
    foreach (rows[i]) begin
      {main_ok, r2_ok, r3_ok} = rows[i][5:3];
      cyc(5);
      chk({early_n, r2_oe, r3_oe}, rows[i][2:0]);
      chk({rst, rst_oe}, {1'b0, !rows[i][5]});
      chk({r2_pin, r3_pin, wdo_pin, sda_o}, 4'h0);
    end
    {main_ok, r2_ok, r3_ok} = 3'h7;
    cyc(ST0 - 2);
    chk(rst_oe, 1'b1);
    wait_rst(1'b0, 20);
    chk(rst_oe, 1'b0);
    // A press shorter than the debounce time must not reach the reset pin
    st_sel = 2'h1;
    mr_n = 1'b0;
    cyc(100);
    mr_n = 1'b1;
    seen = 1'b0;
    repeat (700) begin
      @(negedge mclk_i);
      if (rst_oe !== 1'b0) seen = 1'b1;
    end
    chk(seen, 1'b0);
    mr_n = 1'b0;
    wait_rst(1'b1, 640);
    chk(rst_oe, 1'b1);
    cyc(100);
    mr_n = 1'b1;
    cyc(625 + ST1 - 12);
    chk(rst_oe, 1'b1);
    wait_rst(1'b0, 30);
    chk(rst_oe, 1'b0);
    wp = 1'b1;
    cyc(4);
    sel_write(2'h1);
    chk({wd_sel, wdo_oe}, 3'h1);
    wp = 1'b0;
    cyc(4);
    sel_write(2'h1);
    chk({wd_sel, wdo_oe}, 3'h2);
    // Kick late in the period, so a missed restart would expire before the next check
    cyc(WD1 - 100);
    host.kick(1'b1);
    chk(wdo_oe, 1'b0);
    cyc(WD1 - 60);
    chk(wdo_oe, 1'b0);
    for (int i = 0; i < 100 && wdo_oe !== 1'b1; i++) @(negedge mclk_i);
    chk(wdo_oe, 1'b1);
    host.kick(1'b0);
    chk(wdo_oe, 1'b1);
    drive_low = 1'b1;
    host.kick(1'b1);
    // Our own pull makes the start, so expiry stands until the line is let go
    chk({sda_oe, sda_o, sda_w, wdo_oe}, 4'h9);
    drive_low = 1'b0;
    cyc(3);
    chk(sda_w, 1'b1);
    cyc(2);
    chk(wdo_oe, 1'b0);
    // Mid-run reset, then a power-up stretch on the third select
    st_sel = 2'h2;
    reset_n_i = 1'b0;
    cyc(2);
    chk({rst, rst_oe, wdo_oe, wd_sel, sda_oe}, 6'h10);
    reset_n_i = 1'b1;
    cyc(ST2 - 2);
    chk(rst_oe, 1'b1);
    wait_rst(1'b0, 10);
    chk(rst_oe, 1'b0);
    end_of_test();
  end

  initial begin
    #(20000 * 8);
    bad_count++;
    end_of_test();
  end
endmodule
